// file: logic/wdcsf_top.sv
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - counter overflow in interval mode sets bit 3, never in watchdog mode
// - counter overflow in watchdog mode sets bit 4, never in interval mode
// - bit 5 picks reset kind in watchdog mode, ignored in interval mode
// - bit 6 selects mode: 0 interval (reset value), 1 watchdog
// - flags and reset select reset to zero and read back stored value
// - 8-bit counter counts up; overflow resets or interrupts by mode
// - register written by word with key a5 upper byte; read by byte
// - register cleared only by power-on reset, kept through watchdog reset
module wdcsf_top (
  // clock and power-on reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_resetn,
  // register port
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic        i_reg_word,
  input  wire logic [15:0] i_reg_wdata,
  output var  logic [7:0]  o_reg_rdata,
  output var  logic        o_reg_rvalid,
  // prescaled count strobe from the clock divider
  input  wire logic        i_count_tick,
  // timer outputs
  output var  logic [2:0]  o_clock_select,
  output var  logic        o_power_on_reset_req,
  output var  logic        o_manual_reset_req,
  output var  logic        o_interval_irq
);
  import wdcsf_pkg::*;

  wdcsf_cnt_if cnt_link ();

  logic [2:0] clock_select;
  logic       interval_overflow_flag;
  logic       watchdog_overflow_flag;
  logic       reset_type_select;
  logic       timer_mode_select;
  logic       count_run_enable;

  // decode of the register port
  wire        csr_hit   = i_reg_addr == WDCSF_CSR_OFS;
  wire        cnt_hit   = i_reg_addr == WDCSF_COUNT_OFS;
  wire [7:0]  wkey      = i_reg_wdata[15:8];
  wire [7:0]  wbyte     = i_reg_wdata[7:0];
  // a byte store carrying the key is refused too, so a stray byte
  // write can never arm or retune the timer
  // keyed word writes only
  wire        csr_wr    = i_reg_wr && i_reg_word && csr_hit &&
                          (wkey == WDCSF_CSR_KEY);
  wire        cnt_wr    = i_reg_wr && i_reg_word && cnt_hit &&
                          (wkey == WDCSF_COUNT_KEY);
  // word reads are answered with zero, only byte reads return data
  wire        byte_rd   = i_reg_rd && !i_reg_word;
  wire        ovf       = cnt_link.overflow;
  wire        ovf_wd    = ovf && (timer_mode_select == WDCSF_MODE_WATCHDOG);
  wire        ovf_it    = ovf && (timer_mode_select == WDCSF_MODE_INTERVAL);

  wire [7:0]  csr_value = {count_run_enable, timer_mode_select,
                           reset_type_select, watchdog_overflow_flag,
                           interval_overflow_flag, clock_select};

  // flags: write 0 clears, write 1 keeps; a new overflow wins over clear
  // a set flag stays until software writes 0, so no overflow is missed
  // interval and watchdog flag set
  wire next_iflag = ovf_it | (csr_wr ? interval_overflow_flag &
                    wbyte[WDCSF_IFLAG_BIT] : interval_overflow_flag);
  wire next_wflag = ovf_wd | (csr_wr ? watchdog_overflow_flag &
                    wbyte[WDCSF_WFLAG_BIT] : watchdog_overflow_flag);

  wire [7:0] next_rdata = !byte_rd ? WDCSF_RDATA_RST
                        : csr_hit  ? csr_value
                        : cnt_hit  ? cnt_link.count
                        : WDCSF_RDATA_RST;

  // counter link; the counter lives in its own module so its wrap
  // check sits beside the logic that it guards
  assign cnt_link.tick       = i_count_tick;
  assign cnt_link.run        = count_run_enable;
  assign cnt_link.load       = cnt_wr;
  assign cnt_link.load_value = wbyte;

  wdcsf_counter u_counter (
    .i_sys_clk (i_sys_clk),
    .i_resetn  (i_resetn),
    .cnt       (cnt_link)
  );

  // only power-on reset clears; watchdog reset is an output only
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      clock_select           <= WDCSF_CSR_RST[WDCSF_CKS_MSB:WDCSF_CKS_LSB];
      interval_overflow_flag <= WDCSF_CSR_RST[WDCSF_IFLAG_BIT];
      watchdog_overflow_flag <= WDCSF_CSR_RST[WDCSF_WFLAG_BIT];
      reset_type_select      <= WDCSF_CSR_RST[WDCSF_RSEL_BIT];
      timer_mode_select      <= WDCSF_CSR_RST[WDCSF_MODE_BIT];
      count_run_enable       <= WDCSF_CSR_RST[WDCSF_RUN_BIT];
    end else begin
      interval_overflow_flag <= next_iflag;
      watchdog_overflow_flag <= next_wflag;
      if (csr_wr) begin
        clock_select      <= wbyte[WDCSF_CKS_MSB:WDCSF_CKS_LSB];
        reset_type_select <= wbyte[WDCSF_RSEL_BIT];
        timer_mode_select <= wbyte[WDCSF_MODE_BIT];
        count_run_enable  <= wbyte[WDCSF_RUN_BIT];
      end
    end
  end

  // callers wait one cycle for rvalid; bought with a clean register output
  // read path; data registered, one cycle after the read strobe
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_reg_rdata  <= WDCSF_RDATA_RST;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rdata  <= next_rdata;
      o_reg_rvalid <= i_reg_rd;
    end
  end

  // requests are registered so decode glitches never reach a reset line
  // reset kind chosen by select; 0 power-on, 1 manual
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_power_on_reset_req <= 1'b0;
      o_manual_reset_req   <= 1'b0;
      o_interval_irq       <= 1'b0;
      o_clock_select       <= WDCSF_CSR_RST[WDCSF_CKS_MSB:WDCSF_CKS_LSB];
    end else begin
      o_power_on_reset_req <= ovf_wd &&
                              (reset_type_select == WDCSF_RSEL_POWER_ON);
      o_manual_reset_req   <= ovf_wd &&
                              (reset_type_select == WDCSF_RSEL_MANUAL);
      o_interval_irq       <= ovf_it;
      o_clock_select       <= clock_select;
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);

  iflag_set_a: assert property (ovf_it |=> interval_overflow_flag)
    else $error("interval flag not set on interval overflow");
  iflag_cause_a: assert property (
    $rose(interval_overflow_flag) |-> $past(ovf_it))
    else $error("interval flag rose without interval overflow");
  wflag_set_a: assert property (ovf_wd |=> watchdog_overflow_flag)
    else $error("watchdog flag not set on watchdog overflow");
  wflag_cause_a: assert property (
    $rose(watchdog_overflow_flag) |-> $past(ovf_wd))
    else $error("watchdog flag rose without watchdog overflow");
  it_no_reset_a: assert property (
    ovf_it |=> !o_power_on_reset_req && !o_manual_reset_req)
    else $error("reset issued in interval mode");
  por_kind_a: assert property (
    ovf_wd && !reset_type_select |=> o_power_on_reset_req
    && !o_manual_reset_req)
    else $error("wrong reset kind for select 0");
  manual_kind_a: assert property (
    ovf_wd && reset_type_select |=> o_manual_reset_req
    && !o_power_on_reset_req)
    else $error("wrong reset kind for select 1");
  irq_pulse_a: assert property (
    ovf_it |=> o_interval_irq ##1 !o_interval_irq)
    else $error("interval interrupt not a single pulse");
  key_guard_a: assert property (
    i_reg_wr && csr_hit && !csr_wr
    |=> $stable(timer_mode_select) && $stable(reset_type_select)
    && $stable(count_run_enable))
    else $error("unkeyed write changed the register");
  mode_write_a: assert property (
    csr_wr |=> timer_mode_select == $past(wbyte[WDCSF_MODE_BIT]))
    else $error("mode bit did not take keyed write");
  read_back_a: assert property (
    byte_rd && csr_hit |=> o_reg_rvalid && o_reg_rdata == $past(csr_value))
    else $error("read data differs from stored value");


  // a keyed write of 1 keeps a flag and 0 clears it; a new set wins
  iflag_keep_a: assert property (
    csr_wr && !ovf_it |=> interval_overflow_flag ==
    ($past(interval_overflow_flag) & $past(wbyte[WDCSF_IFLAG_BIT])))
    else $error("interval flag did not follow keyed write");
  wflag_keep_a: assert property (
    csr_wr && !ovf_wd |=> watchdog_overflow_flag ==
    ($past(watchdog_overflow_flag) & $past(wbyte[WDCSF_WFLAG_BIT])))
    else $error("watchdog flag did not follow keyed write");
  // only a keyed write moves the stored bits; reset requests leave them
  csr_hold_a: assert property (
    !csr_wr |=> $stable(timer_mode_select) && $stable(reset_type_select)
    && $stable(count_run_enable) && $stable(clock_select))
    else $error("stored bits moved without a keyed write");
  // a count write without its key leaves the count alone
  count_guard_a: assert property (
    i_reg_wr && cnt_hit && !cnt_wr && !i_count_tick
    |=> $stable(cnt_link.count))
    else $error("unkeyed write changed the count");
  // every read strobe is answered exactly once, one cycle later
  read_answer_a: assert property (
    i_reg_rd |=> o_reg_rvalid)
    else $error("read strobe not answered");
  read_idle_a: assert property (
    !i_reg_rd |=> !o_reg_rvalid && o_reg_rdata == WDCSF_RDATA_RST)
    else $error("read data left standing without a read");
  // reset requests are single-cycle pulses
  reset_pulse_a: assert property (
    o_power_on_reset_req || o_manual_reset_req
    |=> !o_power_on_reset_req && !o_manual_reset_req)
    else $error("reset request longer than one cycle");

  cover_it_ovf_c: cover property (ovf_it ##1 o_interval_irq);
  cover_word_c:   cover property (i_reg_rd && i_reg_word ##1 o_reg_rvalid);
  cover_por_c:    cover property (o_power_on_reset_req);
  cover_man_c:    cover property (o_manual_reset_req);
  cover_clear_c:  cover property (interval_overflow_flag ##1
                                  !interval_overflow_flag);
endmodule : wdcsf_top
`default_nettype wire

// file: logic/wdcsf_pkg.sv
package wdcsf_pkg;
  // register offsets on the register port
  localparam logic [7:0]  WDCSF_COUNT_OFS   = 8'h08;
  localparam logic [7:0]  WDCSF_CSR_OFS     = 8'h0c;
  // write keys carried in the upper byte of a word write
  localparam logic [7:0]  WDCSF_COUNT_KEY   = 8'h5a;
  localparam logic [7:0]  WDCSF_CSR_KEY     = 8'ha5;
  // field positions inside watchdog_control_status
  localparam int          WDCSF_CKS_LSB     = 0;
  localparam int          WDCSF_CKS_MSB     = 2;
  localparam int          WDCSF_IFLAG_BIT   = 3;
  localparam int          WDCSF_WFLAG_BIT   = 4;
  localparam int          WDCSF_RSEL_BIT    = 5;
  localparam int          WDCSF_MODE_BIT    = 6;
  localparam int          WDCSF_RUN_BIT     = 7;
  // reset values and count maximum
  localparam logic [7:0]  WDCSF_CSR_RST     = 8'h00;
  localparam logic [7:0]  WDCSF_COUNT_RST   = 8'h00;
  localparam logic [7:0]  WDCSF_COUNT_MAX   = 8'hff;
  localparam logic [7:0]  WDCSF_RDATA_RST   = 8'h00;
  // timer mode and reset type encodings
  localparam logic        WDCSF_MODE_INTERVAL = 1'b0;
  localparam logic        WDCSF_MODE_WATCHDOG = 1'b1;
  localparam logic        WDCSF_RSEL_POWER_ON = 1'b0;
  localparam logic        WDCSF_RSEL_MANUAL   = 1'b1;
endpackage : wdcsf_pkg

// file: logic/wdcsf_cnt_if.sv
`timescale 1ns/1ns
`default_nettype none
// signals between the flag logic and the 8-bit up-counter
interface wdcsf_cnt_if;
  logic       tick;       // prescaled count strobe
  logic       run;        // count_run_enable
  logic       load;       // keyed write to watchdog_count
  logic [7:0] load_value;
  logic [7:0] count;      // current watchdog_count
  logic       overflow;   // one-cycle pulse after wrap
  modport ctl (output tick, run, load, load_value, input count, overflow);
  modport cnt (input tick, run, load, load_value, output count, overflow);
endinterface : wdcsf_cnt_if
`default_nettype wire

// file: logic/wdcsf_counter.sv
`timescale 1ns/1ns
`default_nettype none
module wdcsf_counter (
  // clock and power-on reset
  input  wire logic   i_sys_clk,
  input  wire logic   i_resetn,
  // counter side of the link
  wdcsf_cnt_if.cnt    cnt
);
  import wdcsf_pkg::*;

  logic [7:0] count;
  logic       overflow;
  wire        step     = cnt.tick && cnt.run;
  wire        wrap     = step && (count == WDCSF_COUNT_MAX) && !cnt.load;
  wire [7:0]  next_count = cnt.load ? cnt.load_value
                         : step     ? count + 8'h01
                         : count;

  // up-count on strobe
  // software load beats a count in the same cycle
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      count    <= WDCSF_COUNT_RST;
      overflow <= 1'b0;
    end else begin
      count    <= next_count;
      overflow <= wrap;
    end
  end

  assign cnt.count    = count;
  assign cnt.overflow = overflow;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);

  count_wrap_a: assert property (
    wrap |=> (count == WDCSF_COUNT_RST) && overflow)
    else $error("counter did not wrap with overflow");
  count_hold_a: assert property (
    !step && !cnt.load |=> $stable(count))
    else $error("counter moved without strobe or load");
endmodule : wdcsf_counter
`default_nettype wire

// file: verification/wdcsf_tb.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import wdcsf_pkg::*;
  logic        i_sys_clk;
  logic        i_resetn;
  logic [7:0]  i_reg_addr;
  logic        i_reg_wr;
  logic        i_reg_rd;
  logic        i_reg_word;
  logic [15:0] i_reg_wdata;
  logic        i_count_tick;
  logic [7:0]  o_reg_rdata;
  logic        o_reg_rvalid;
  logic [2:0]  o_clock_select;
  logic        o_power_on_reset_req;
  logic        o_manual_reset_req;
  logic        o_interval_irq;
  int          bad_count;
  int          comparisons;
  int          cycles;
  logic [2:0]  seen;

  wdcsf_top i_wdcsf_top (
    .i_sys_clk            (i_sys_clk),
    .i_resetn             (i_resetn),
    .i_reg_addr           (i_reg_addr),
    .i_reg_wr             (i_reg_wr),
    .i_reg_rd             (i_reg_rd),
    .i_reg_word           (i_reg_word),
    .i_reg_wdata          (i_reg_wdata),
    .o_reg_rdata          (o_reg_rdata),
    .o_reg_rvalid         (o_reg_rvalid),
    .i_count_tick         (i_count_tick),
    .o_clock_select       (o_clock_select),
    .o_power_on_reset_req (o_power_on_reset_req),
    .o_manual_reset_req   (o_manual_reset_req),
    .o_interval_irq       (o_interval_irq)
  );

  // free running 125 MHz clock
  initial begin
    i_sys_clk = 1'b0;
    forever #4 i_sys_clk = ~i_sys_clk;
  end

  task automatic close_out;
    $display("mismatches %0d of %0d comparisons", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out

  // cuts a hang short; the full run needs well under 1000 cycles
  always @(posedge i_sys_clk) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      bad_count = bad_count + 1;
      close_out();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string msg);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  // one strobe cycle; strobes drop one cycle later so none is set twice
  task automatic wr(input logic [7:0] addr, input logic [15:0] data,
                    input logic word);
    @(posedge i_sys_clk) #1;
    i_reg_addr  = addr;
    i_reg_wdata = data;
    i_reg_word  = word;
    i_reg_wr    = 1'b1;
    @(posedge i_sys_clk) #1;
    i_reg_wr    = 1'b0;
  endtask : wr

  // read; rvalid and rdata stand in the cycle after the strobe
  task automatic rd(input logic [7:0] addr, input logic [7:0] exp,
                    input logic word);
    @(posedge i_sys_clk) #1;
    i_reg_addr = addr;
    i_reg_word = word;
    i_reg_rd   = 1'b1;
    @(posedge i_sys_clk) #1;
    i_reg_rd   = 1'b0;
    chk({7'h00, o_reg_rvalid}, 8'h01, "read valid");
    chk(o_reg_rdata, exp, "read data");
  endtask : rd

  // load ff, give one tick, gather {irq, power-on, manual} pulses
  task automatic boom(input logic [2:0] exp);
    wr(WDCSF_COUNT_OFS, {WDCSF_COUNT_KEY, 8'hff}, 1'b1);
    seen = 3'b000;
    @(posedge i_sys_clk) #1;
    i_count_tick = 1'b1;
    @(posedge i_sys_clk) #1;
    i_count_tick = 1'b0;
    repeat (6) begin
      @(posedge i_sys_clk) #1;
      seen = seen | {o_interval_irq, o_power_on_reset_req,
                     o_manual_reset_req};
    end
    chk({5'h00, seen}, {5'h00, exp}, "overflow outputs");
  endtask : boom

  // main sequence
  initial begin
    bad_count = 0;
    comparisons = 0;
    cycles = 0;
    i_resetn = 1'b0;
    i_reg_addr = 8'h00;
    i_reg_wr = 1'b0;
    i_reg_rd = 1'b0;
    i_reg_word = 1'b0;
    i_reg_wdata = 16'h0000;
    i_count_tick = 1'b0;
    repeat (3) @(posedge i_sys_clk);
    #1 i_resetn = 1'b1;
    rd(WDCSF_CSR_OFS, WDCSF_CSR_RST, 1'b0);
    rd(WDCSF_COUNT_OFS, WDCSF_COUNT_RST, 1'b0);
    rd(8'h10, 8'h00, 1'b0);
    // word reads are answered, with zero data
    rd(WDCSF_CSR_OFS, 8'h00, 1'b1);
    wr(WDCSF_CSR_OFS, 16'h0040, 1'b1);
    wr(WDCSF_CSR_OFS, 16'ha540, 1'b0);
    rd(WDCSF_CSR_OFS, 8'h00, 1'b0);
    wr(WDCSF_CSR_OFS, 16'ha540, 1'b1);
    rd(WDCSF_CSR_OFS, 8'h40, 1'b0);
    // interval mode while stopped, then run with clock select 7
    wr(WDCSF_CSR_OFS, 16'ha507, 1'b1);
    wr(WDCSF_CSR_OFS, 16'ha587, 1'b1);
    @(posedge i_sys_clk) #1;
    chk({5'h00, o_clock_select}, 8'h07, "clock select");
    boom(3'b100);
    rd(WDCSF_CSR_OFS, 8'h8f, 1'b0);
    // stop first, keeping the interval flag by writing it as 1
    wr(WDCSF_CSR_OFS, 16'ha50f, 1'b1);
    rd(WDCSF_CSR_OFS, 8'h0f, 1'b0);
    // watchdog mode while stopped; writing 0 clears the interval flag
    wr(WDCSF_CSR_OFS, 16'ha540, 1'b1);
    wr(WDCSF_CSR_OFS, 16'ha5c0, 1'b1);
    boom(3'b010);
    rd(WDCSF_CSR_OFS, 8'hd0, 1'b0);
    wr(WDCSF_CSR_OFS, 16'ha5e0, 1'b1);
    boom(3'b001);
    rd(WDCSF_CSR_OFS, 8'hf0, 1'b0);
    // stop keeping the watchdog flag, then interval mode while stopped
    wr(WDCSF_CSR_OFS, 16'ha570, 1'b1);
    rd(WDCSF_CSR_OFS, 8'h70, 1'b0);
    wr(WDCSF_CSR_OFS, 16'ha520, 1'b1);
    // interval mode ignores the reset kind bit
    wr(WDCSF_CSR_OFS, 16'ha5a0, 1'b1);
    boom(3'b100);
    rd(WDCSF_CSR_OFS, 8'ha8, 1'b0);
    // stopped timer must not count
    wr(WDCSF_CSR_OFS, 16'ha520, 1'b1);
    boom(3'b000);
    rd(WDCSF_COUNT_OFS, 8'hff, 1'b0);
    // the count takes only writes carrying its own key
    wr(WDCSF_COUNT_OFS, {WDCSF_CSR_KEY, 8'h33}, 1'b1);
    rd(WDCSF_COUNT_OFS, 8'hff, 1'b0);
    rd(WDCSF_CSR_OFS, 8'h20, 1'b0);
    // power-on reset with the timer stopped clears everything
    @(posedge i_sys_clk) #1;
    i_resetn = 1'b0;
    repeat (2) @(posedge i_sys_clk);
    #1 i_resetn = 1'b1;
    rd(WDCSF_CSR_OFS, WDCSF_CSR_RST, 1'b0);
    rd(WDCSF_COUNT_OFS, WDCSF_COUNT_RST, 1'b0);
    close_out();
  end
endmodule : testbench
`default_nettype wire
